/* File: core/vrc_pkg.sv */
// Constants, types and helpers shared by the reference control block.
// Assumes a 32-bit classic Wishbone bus with byte lane 0 carrying all data.

package vrc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned VRC_ADR_W  = 8;
  localparam int unsigned VRC_BUS_W  = 32;
  localparam int unsigned VRC_REG_W  = 8;
  localparam int unsigned VRC_CODE_W = 4;
  localparam int unsigned VRC_TAP_W  = 6;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [VRC_ADR_W-1:0] VRC_ADR_SLOT = 8'h00; // Shared slot
  localparam logic [VRC_ADR_W-1:0] VRC_ADR_WDT  = 8'h04; // Watchdog control
  localparam logic [VRC_ADR_W-1:0] VRC_ADR_STAT = 8'h08; // Live state

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned VRC_BIT_POWER  = 7;
  localparam int unsigned VRC_BIT_PIN    = 6;
  localparam int unsigned VRC_BIT_RANGE  = 5;
  localparam int unsigned VRC_BIT_SOURCE = 4;
  localparam int unsigned VRC_CODE_HI    = 3;
  localparam int unsigned VRC_CODE_LO    = 0;
  localparam int unsigned VRC_BIT_ALT    = 4;
  localparam int unsigned VRC_STAT_TAP_HI = 5;
  localparam int unsigned VRC_STAT_DIR   = 6;
  localparam int unsigned VRC_STAT_ALT   = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [VRC_REG_W-1:0] VRC_CTRL_RST   = 8'h00;
  localparam logic [VRC_REG_W-1:0] VRC_PERIOD_RST = 8'h00;
  localparam logic                 VRC_ALT_RST    = 1'b0;

  // ----------------------------------------------------------------
  // Ladder geometry
  // ----------------------------------------------------------------
  localparam logic [VRC_TAP_W-1:0] VRC_DEN_LOW   = 6'h18; // Steps of 1/24
  localparam logic [VRC_TAP_W-1:0] VRC_DEN_HIGH  = 6'h20; // Steps of 1/32
  localparam logic [VRC_TAP_W-1:0] VRC_HIGH_BASE = 6'h08; // Quarter of 32

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {
    VRC_BUS_IDLE = 1'b0,
    VRC_BUS_ACK  = 1'b1
  } vrc_bus_st_t;

  // Tap numerator over the selected denominator
  function automatic logic [VRC_TAP_W-1:0] vrc_tap_numer(
    input logic                  range_low,
    input logic [VRC_CODE_W-1:0] code
  );
    logic [VRC_TAP_W-1:0] wide;
    wide = {2'b00, code};
    return range_low ? wide : VRC_HIGH_BASE + wide;
  endfunction

endpackage

/* File: core/vrc_slot_if.sv */
// Carrier between the bus front end and the shared-address register slot.
// Assumes both ends run on the same system clock.

`timescale 1ns/100ps

interface vrc_slot_if;
  logic       wr_en;   // One-cycle write strobe into the slot
  logic [7:0] wdata;   // Byte to store
  logic       alt_sel; // Alternate map selected
  logic [7:0] rdata;   // Byte visible at the slot address
  logic [7:0] ctrl;    // Stored reference control byte
  logic [7:0] period;  // Stored timer period byte

  modport bus  (output wr_en, wdata, alt_sel, input rdata, ctrl, period);
  modport slot (input wr_en, wdata, alt_sel, output rdata, ctrl, period);
endinterface

/* File: core/vrc_slot.sv */
// Shared-address slot: reference control and timer period registers.
// Assumes write strobes arrive already qualified by address and lane.

`timescale 1ns/100ps

module vrc_slot (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_srst,
  // Front end
  vrc_slot_if.slot  slot
);
  import vrc_pkg::*;

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] period_q;
  logic [7:0] period_d;

  // ----------------------------------------------------------------
  // Write steering
  // ----------------------------------------------------------------
  // alternate bit picks target
  always_comb begin
    ctrl_d   = ctrl_q;
    period_d = period_q;
    if (slot.wr_en && slot.alt_sel) begin
      ctrl_d = slot.wdata;
    end else if (slot.wr_en) begin
      period_d = slot.wdata;
    end
  end

  // wake keeps contents
  // Only reset clears; sleep and wake never touch these flops
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ctrl_q   <= VRC_CTRL_RST;
      period_q <= VRC_PERIOD_RST;
    end else begin
      ctrl_q   <= ctrl_d;
      period_q <= period_d;
    end
  end

  // Read view and stored values
  assign slot.rdata  = slot.alt_sel ? ctrl_q : period_q;
  assign slot.ctrl   = ctrl_q;
  assign slot.period = period_q;

endmodule

/* File: core/vrc_top.sv */
// Voltage reference control: Wishbone slave, shared slot, ladder controls.
// Assumes a classic Wishbone master on i_sys_clk and an analog ladder
// that takes its controls as static levels.
//
// Contract
// - Bit 7 powers ladder on or down
// - Bit 6 routes level onto pin
// - Pin drive overrides port direction bit
// - Bit 5 picks low or high range
// - Bit 4 picks external or analog supply
// - Low four bits pick ladder tap
// - Reset clears whole control register
// - Shared address needs alternate bit set
// - Wake from sleep keeps register contents
// - Works regardless of comparator state
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.

`timescale 1ns/100ps

module vrc_top (
  // Clock and reset
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_srst,
  // Wishbone slave
  input  wire logic                           i_wb_cyc,
  input  wire logic                           i_wb_stb,
  input  wire logic                           i_wb_we,
  input  wire logic [vrc_pkg::VRC_ADR_W-1:0]  i_wb_adr,
  input  wire logic [3:0]                     i_wb_sel,
  input  wire logic [vrc_pkg::VRC_BUS_W-1:0]  i_wb_dat,
  output logic                                o_wb_ack,
  output logic      [vrc_pkg::VRC_BUS_W-1:0]  o_wb_dat,
  // Port logic
  input  wire logic                           i_port_f_direction,
  output logic                                o_pin_dir_eff,
  // Ladder controls
  output logic                                o_ref_power_on,
  output logic                                o_ref_pin_drive,
  output logic                                o_ref_range_sel,
  output logic                                o_ref_source_sel,
  output logic      [vrc_pkg::VRC_CODE_W-1:0] o_ref_level_code,
  output logic      [vrc_pkg::VRC_TAP_W-1:0]  o_tap_numer,
  output logic      [vrc_pkg::VRC_TAP_W-1:0]  o_tap_denom,
  // Timer side
  output logic      [vrc_pkg::VRC_REG_W-1:0]  o_timer_period
);
  import vrc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  vrc_slot_if slot_if ();

  vrc_bus_st_t            bus_q;
  vrc_bus_st_t            bus_d;
  logic [VRC_BUS_W-1:0]   dat_q;
  logic [VRC_BUS_W-1:0]   dat_d;
  logic                   alt_q;
  logic                   alt_d;
  logic                   dir_q;
  logic                   dir_d;
  logic [VRC_TAP_W-1:0]   numer_q;
  logic [VRC_TAP_W-1:0]   numer_d;
  logic [VRC_TAP_W-1:0]   denom_q;
  logic [VRC_TAP_W-1:0]   denom_d;
  logic                   req;
  logic                   wr_take;
  logic                   hit_slot;
  logic                   hit_wdt;
  logic                   hit_stat;
  logic [VRC_REG_W-1:0]   rd_byte;
  logic [VRC_REG_W-1:0]   stat_byte;
  logic [VRC_REG_W-1:0]   ctrl;

  // ----------------------------------------------------------------
  // Register slot
  // ----------------------------------------------------------------
  vrc_slot u_slot (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .slot      (slot_if.slot)
  );

  assign ctrl = slot_if.ctrl;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Request qualifier and write moment
  // Writes land on the ack edge so the master sees them take effect there
  assign req     = i_wb_cyc & i_wb_stb;
  assign wr_take = req & i_wb_we & i_wb_sel[0] & (bus_q == VRC_BUS_ACK);

  // Address decode
  always_comb begin
    hit_slot = 1'b0;
    hit_wdt  = 1'b0;
    hit_stat = 1'b0;
    if (i_wb_adr == VRC_ADR_SLOT) begin
      hit_slot = 1'b1;
    end else if (i_wb_adr == VRC_ADR_WDT) begin
      hit_wdt = 1'b1;
    end else if (i_wb_adr == VRC_ADR_STAT) begin
      hit_stat = 1'b1;
    end
  end

  // Status view of live state
  always_comb begin
    stat_byte = '0;
    stat_byte[VRC_STAT_TAP_HI:0] = numer_q;
    stat_byte[VRC_STAT_DIR]      = dir_q;
    stat_byte[VRC_STAT_ALT]      = alt_q;
  end

  // Read multiplexer, unmapped reads as zero
  always_comb begin
    rd_byte = '0;
    if (hit_slot) begin
      rd_byte = slot_if.rdata;
    end else if (hit_wdt) begin
      rd_byte[VRC_BIT_ALT] = alt_q;
    end else if (hit_stat) begin
      rd_byte = stat_byte;
    end
  end

  // One ack per request, then one idle cycle before the next
  always_comb begin
    bus_d = VRC_BUS_IDLE;
    dat_d = '0;
    case (bus_q)
      VRC_BUS_IDLE: begin
        if (req) begin
          bus_d = VRC_BUS_ACK;
          dat_d = {{(VRC_BUS_W-VRC_REG_W){1'b0}}, rd_byte};
        end
      end
      VRC_BUS_ACK: begin
        bus_d = VRC_BUS_IDLE;
      end
      default: begin
        bus_d = VRC_BUS_IDLE;
      end
    endcase
  end

  // Bus state registers
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      bus_q <= VRC_BUS_IDLE;
      dat_q <= '0;
    end else begin
      bus_q <= bus_d;
      dat_q <= dat_d;
    end
  end

  // ----------------------------------------------------------------
  // Alternate map select
  // ----------------------------------------------------------------
  // alternate bit storage
  always_comb begin
    alt_d = alt_q;
    if (wr_take && hit_wdt) begin
      alt_d = i_wb_dat[VRC_BIT_ALT];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      alt_q <= VRC_ALT_RST;
    end else begin
      alt_q <= alt_d;
    end
  end

  // Slot strobes
  assign slot_if.wr_en   = wr_take & hit_slot;
  assign slot_if.wdata   = i_wb_dat[VRC_REG_W-1:0];
  assign slot_if.alt_sel = alt_q;

  // ----------------------------------------------------------------
  // Pin and ladder derived controls
  // ----------------------------------------------------------------
  // pin drive wins
  // Direction comes from port logic on this clock, so no synchroniser
  always_comb begin
    dir_d = ctrl[VRC_BIT_PIN] ? 1'b1 : i_port_f_direction;
  end

  always_comb begin
    numer_d = vrc_tap_numer(ctrl[VRC_BIT_RANGE], ctrl[VRC_CODE_HI:VRC_CODE_LO]);
    denom_d = ctrl[VRC_BIT_RANGE] ? VRC_DEN_LOW : VRC_DEN_HIGH;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      dir_q   <= 1'b1;
      numer_q <= VRC_HIGH_BASE;
      denom_q <= VRC_DEN_HIGH;
    end else begin
      dir_q   <= dir_d;
      numer_q <= numer_d;
      denom_q <= denom_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // static ladder controls
  assign o_wb_ack         = (bus_q == VRC_BUS_ACK);
  assign o_wb_dat         = dat_q;
  assign o_pin_dir_eff    = dir_q;
  assign o_ref_power_on   = ctrl[VRC_BIT_POWER];
  assign o_ref_pin_drive  = ctrl[VRC_BIT_PIN];
  assign o_ref_range_sel  = ctrl[VRC_BIT_RANGE];
  assign o_ref_source_sel = ctrl[VRC_BIT_SOURCE];
  assign o_ref_level_code = ctrl[VRC_CODE_HI:VRC_CODE_LO];
  assign o_tap_numer      = numer_q;
  assign o_tap_denom      = denom_q;
  assign o_timer_period   = slot_if.period;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic wr_ctrl;
  assign wr_ctrl = slot_if.wr_en & alt_q;

  a_power_follows_write: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    wr_ctrl |=> o_ref_power_on == $past(i_wb_dat[VRC_BIT_POWER]))
    else $error("power bit did not follow write");

  a_pin_route_write: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    wr_ctrl |=> o_ref_pin_drive == $past(i_wb_dat[VRC_BIT_PIN]))
    else $error("pin route bit did not follow write");

  a_pin_dir_override: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    o_ref_pin_drive && $past(o_ref_pin_drive) |-> o_pin_dir_eff)
    else $error("pin direction not overridden");

  a_range_denom: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $stable(o_ref_range_sel) |=> o_tap_denom ==
      ($past(o_ref_range_sel) ? VRC_DEN_LOW : VRC_DEN_HIGH))
    else $error("tap denominator wrong for range");

  a_source_sel_write: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    wr_ctrl |=> o_ref_source_sel == $past(i_wb_dat[VRC_BIT_SOURCE]))
    else $error("source select did not follow write");

  a_tap_from_code: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    wr_ctrl |=> ##1 o_tap_numer == vrc_tap_numer($past(i_wb_dat[VRC_BIT_RANGE], 2),
      $past(i_wb_dat[VRC_CODE_HI:VRC_CODE_LO], 2)))
    else $error("tap numerator wrong for code");

  a_reset_clears: assert property (@(posedge i_sys_clk)
    i_srst |=> ctrl == VRC_CTRL_RST && !o_ref_power_on && !o_ref_pin_drive)
    else $error("control not cleared by reset");

  a_shared_slot_sel: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    slot_if.wr_en && !alt_q |=> $stable(ctrl) &&
      o_timer_period == $past(i_wb_dat[VRC_REG_W-1:0]))
    else $error("shared slot wrote wrong register");

  a_hold_no_write: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !wr_ctrl |=> $stable(ctrl))
    else $error("control changed without a write");

  a_ack_one_cycle: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    req && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack not single cycle");

  // direction copies port bit when not driven
  a_dir_follow_port: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !o_ref_pin_drive |=> o_pin_dir_eff == $past(i_port_f_direction))
    else $error("direction did not follow port bit");

  a_alt_follow_write: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    wr_take && hit_wdt |=> alt_q == $past(i_wb_dat[VRC_BIT_ALT]))
    else $error("alternate select did not follow write");

  // read data stays zero outside ack
  a_rdata_idle_zero: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !o_wb_ack |-> o_wb_dat == '0)
    else $error("read data not zero while idle");

endmodule

/* File: dv/tb.sv */
// Self-checking bench for the reference control block, random and corner stimulus.
// Assumes vrc_pkg and vrc_top are compiled first; the bench is the bus master.

`timescale 1ns/100ps

module tb;
  import vrc_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                  clk      = 1'b0;
  logic                  srst     = 1'b1;
  logic                  cyc      = 1'b0;
  logic                  stb      = 1'b0;
  logic                  we       = 1'b0;
  logic [VRC_ADR_W-1:0]  adr      = 8'h00;
  logic [3:0]            sel      = 4'h0;
  logic [VRC_BUS_W-1:0]  wdat     = 32'h0000_0000;
  logic                  dir_in   = 1'b0;
  logic                  ack, dir_eff, pwr, pin, rng, src;
  logic [VRC_BUS_W-1:0]  rdat, q;
  logic [VRC_CODE_W-1:0] code;
  logic [VRC_TAP_W-1:0]  numer, denom;
  logic [VRC_REG_W-1:0]  period;
  logic [7:0]            m_ctrl, m_period; // Bench copies of the stored bytes
  logic                  m_alt;
  logic [31:0]           d;
  int                    n_errors    = 0;
  int                    comparisons = 0;
  int                    seed        = 1;

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  vrc_top uut (
    .i_sys_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
    .i_port_f_direction(dir_in), .o_pin_dir_eff(dir_eff), .o_ref_power_on(pwr),
    .o_ref_pin_drive(pin), .o_ref_range_sel(rng), .o_ref_source_sel(src),
    .o_ref_level_code(code), .o_tap_numer(numer), .o_tap_denom(denom),
    .o_timer_period(period)
  );

  // ----------------------------------------------------------------
  // Expectations, checks and bus cycles
  // ----------------------------------------------------------------
  // Low range counts from zero, high range starts a quarter up (8 of 32)
  function automatic logic [5:0] exp_numer(input logic [7:0] c);
    return c[5] ? {2'b00, c[3:0]} : 6'h08 + {2'b00, c[3:0]};
  endfunction

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle; held until ack is sampled, bounded wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] dv);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= dv;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: ack %h expected %h", $time, ack, 1'b1);
      print_verdict();
    end else begin
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    xfer(1'b1, a, 4'h1, dv);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 4'h0, 32'h0000_0000);
    check(q, exp);
  endtask

  // Let the ctrl and tap registers land, then compare every ladder control
  task automatic check_pins();
    repeat (2) @(posedge clk);
    #1;
    check(pwr, m_ctrl[7]);
    check(pin, m_ctrl[6]);
    check(rng, m_ctrl[5]);
    check(src, m_ctrl[4]);
    check(code, m_ctrl[3:0]);
    check(numer, exp_numer(m_ctrl));
    check(denom, m_ctrl[5] ? VRC_DEN_LOW : VRC_DEN_HIGH);
    check(period, m_period);
    check(dir_eff, m_ctrl[6] | dir_in);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    m_ctrl = 8'h00;
    m_period = 8'h00;
    m_alt = 1'b0;
    check_pins();
    // alternate bit clear reaches the period byte only
    d = $random(seed);
    m_period = d[7:0];
    wr(VRC_ADR_SLOT, d);
    check_pins();
    rd(VRC_ADR_SLOT, {24'h00_0000, m_period});
    // Only bit 4 of watchdog control is kept
    wr(VRC_ADR_WDT, 32'h0000_00ff);
    m_alt = 1'b1;
    rd(VRC_ADR_WDT, 32'h0000_0010);
    rd(VRC_ADR_SLOT, 32'h0000_0000);
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      case (i)
        0: d[7:0] = 8'hff;
        1: d[7:0] = 8'h20;
        2: d[7:0] = 8'h0f;
        3: d[7:0] = 8'h2f;
        default: ;
      endcase
      dir_in <= d[8];
      m_ctrl = d[7:0];
      wr(VRC_ADR_SLOT, d);
      check_pins();
      rd(VRC_ADR_SLOT, {24'h00_0000, m_ctrl});
      rd(VRC_ADR_STAT, {24'h00_0000, m_alt, m_ctrl[6] | dir_in, exp_numer(m_ctrl)});
    end
    // pin drive wins over the direction bit
    for (int i = 0; i < 4; i++) begin
      m_ctrl = {1'b1, i[1], 6'h05};
      wr(VRC_ADR_SLOT, {24'h00_0000, m_ctrl});
      dir_in <= i[0];
      check_pins();
    end
    // period write with alternate bit clear leaves ctrl alone
    wr(VRC_ADR_WDT, 32'h0000_0000);
    m_alt = 1'b0;
    m_period = 8'ha5;
    wr(VRC_ADR_SLOT, 32'h0000_00a5);
    check_pins();
    // Lane 0 off, read-only status and unmapped place: writes ignored
    xfer(1'b1, VRC_ADR_SLOT, 4'he, 32'h0000_005a);
    wr(VRC_ADR_STAT, 32'h0000_00ff);
    wr(8'h0c, 32'h0000_00ff);
    rd(8'h0c, 32'h0000_0000);
    rd(VRC_ADR_STAT, {24'h00_0000, m_alt, m_ctrl[6] | dir_in, exp_numer(m_ctrl)});
    check_pins();
    // software powers the ladder down before the quiet spell
    wr(VRC_ADR_WDT, 32'h0000_0010);
    m_alt = 1'b1;
    m_ctrl[7] = 1'b0;
    wr(VRC_ADR_SLOT, {24'h00_0000, m_ctrl});
    // contents hold through a long quiet spell
    repeat (200) begin
      @(posedge clk);
      d = $random(seed);
      dir_in <= d[0];
    end
    check_pins();
    // reset in mid-run clears ctrl, period and the alternate bit again
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    m_ctrl = 8'h00;
    m_period = 8'h00;
    m_alt = 1'b0;
    check_pins();
    rd(VRC_ADR_WDT, 32'h0000_0000);
    print_verdict();
  end
endmodule
